//--- design/rsc_pkg.sv
// Shared register layouts, offsets, reset values and codes for the radio state and offset bank.
package rsc_pkg;

  // Register indices; the byte address on APB is four times the index.
  localparam logic [17:0] NEXT_STATE_INDEX = 18'h0df13;
  localparam logic [17:0] CALIBRATION_INDEX = 18'h0df14;
  localparam logic [17:0] OFFSET_COMP_INDEX = 18'h0df15;
  localparam logic [19:0] NEXT_STATE_ADDR = {NEXT_STATE_INDEX, 2'h0};
  localparam logic [19:0] CALIBRATION_ADDR = {CALIBRATION_INDEX, 2'h0};
  localparam logic [19:0] OFFSET_COMP_ADDR = {OFFSET_COMP_INDEX, 2'h0};
  localparam int MIN_ADDR_WIDTH = 20;

  localparam logic [7:0] NEXT_STATE_RESET = 8'h30;
  localparam logic [7:0] CALIBRATION_RESET = 8'h04;
  localparam logic [7:0] OFFSET_COMP_RESET = 8'h76;
  localparam logic [7:0] NEXT_STATE_MASK = 8'h3f;
  localparam logic [7:0] CALIBRATION_MASK = 8'h3f;
  localparam logic [7:0] OFFSET_COMP_MASK = 8'h7f;

  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] clear_channel_select;
    logic [1:0] after_receive_state;
    logic [1:0] after_transmit_state;
  } rsc_next_state_reg_type;

  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] synth_auto_calibrate;
    logic [3:0] reserved;
  } rsc_calibration_reg_type;

  typedef struct packed {
    logic unused;
    logic reserved;
    logic loops_carrier_gate;
    logic [1:0] offset_gain_presync;
    logic offset_gain_postsync;
    logic [1:0] offset_saturation_limit;
  } rsc_offset_comp_reg_type;

  typedef enum logic [1:0] {CCA_ALWAYS, CCA_RSSI_LOW, CCA_NOT_RECEIVING, CCA_RSSI_LOW_NOT_RECEIVING}
    rsc_clear_channel_select_type;
  typedef enum logic [1:0] {CAL_NEVER, CAL_ON_START, CAL_ON_RETURN, CAL_EVERY_FOURTH}
    rsc_cal_mode_type;
  // Both next-state fields share this order, so a field value casts straight to it.
  typedef enum logic [1:0] {RADIO_IDLE, RADIO_SYNTH_ON_FOR_TRANSMIT, RADIO_TRANSMIT, RADIO_RECEIVE}
    rsc_radio_state_type;
  typedef enum logic [1:0] {SEL_NONE, SEL_NEXT_STATE, SEL_CALIBRATION, SEL_OFFSET_COMP}
    rsc_reg_sel_type;

  localparam logic [1:0] CAL_COUNT_LAST = 2'h3;
  localparam logic [1:0] LIMIT_NONE = 2'h0;
  localparam logic [1:0] LIMIT_EIGHTH = 2'h1;
  localparam logic [1:0] LIMIT_QUARTER = 2'h2;
  localparam logic [1:0] SHIFT_EIGHTH = 2'h3;
  localparam logic [1:0] SHIFT_QUARTER = 2'h2;
  localparam logic [1:0] SHIFT_HALF = 2'h1;
  localparam logic [3:0] GAIN_HALF_K = 4'h1;

  typedef struct packed {
    rsc_next_state_reg_type next_state_reg;
    rsc_calibration_reg_type calibration_reg;
    rsc_offset_comp_reg_type offset_comp_reg;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic clear_channel;
    logic sync_seen;
    logic carrier_seen;
    logic [1:0] cal_count;
    logic calibrate_request;
    logic next_state_valid;
    rsc_radio_state_type next_state;
    logic preamble_restart;
    logic loops_frozen;
    logic [3:0] offset_gain;
    logic limit_enable;
    logic [1:0] limit_shift;
  } rsc_state_type;

endpackage

//--- design/rsc_radio_config.sv
// APB register bank steering clear channel, next state, calibration and offset compensation.
//
// Summary of operation
// - Clear channel select sits at bits 5:4 of the next state register, resets to 11.
// - Clear channel: always, RSSI low, not receiving, or RSSI low and not receiving.
// - After receive go to idle, synth-on-for-transmit, transmit or stay in receive.
// - After transmit go to idle, synth-on, stay transmitting with preamble, or receive.
// - Auto-calibrate field at bits 5:4 resets 00; 00 means only the strobe calibrates.
// - Mode 01 calibrates on every exit from idle into an active state.
// - Mode 10 calibrates on each automatic return from receive or transmit to idle.
// - Mode 11 counts automatic returns to idle and calibrates on every fourth.
// - Calibration bits 3:0 are reserved, reset to 0100, and are written 0100.
// - Offset bit 6 is reserved, resets to 1, and software writes it 0.
// - With the gate bit set, both loops stay frozen until carrier sense goes high.
// - Pre-sync loop gain from bits 4:3: K, 2K, 3K or 4K, reset 3K.
// - Post-sync gain bit 2: 0 keeps pre-sync gain, 1 uses K/2.
// - Saturation limit bits 1:0: none, bandwidth over 8, over 4, over 2.
`timescale 1ns/10ps
`default_nettype none

module rsc_radio_config #(
  parameter int ADDR_WIDTH = 20
) (
  input wire logic pclk, // APB clock, 25 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [ADDR_WIDTH-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic pready, // APB transfer done.
  output logic pslverr, // APB error on unmapped address.
  output logic [31:0] prdata, // APB read data.
  input wire logic rssi_below_threshold, // Signal strength under threshold.
  input wire logic packet_receiving, // A packet is being received.
  input wire logic packet_received, // Pulse, a packet was received.
  input wire logic packet_sent, // Pulse, a packet was sent.
  input wire logic idle_exit, // Pulse, leaving idle for an active state.
  input wire logic auto_idle_return, // Pulse, automatic return to idle.
  input wire logic calibrate_strobe, // Pulse, manual calibrate command.
  input wire logic reception_start, // Pulse, a new reception begins.
  input wire logic sync_detected, // Sync word detected.
  input wire logic carrier_sense, // Carrier sense level.
  output logic clear_channel, // Clear channel indication.
  output logic calibrate_request, // Pulse, calibrate the synthesizer.
  output logic next_state_valid, // Pulse, next_state holds a decision.
  output rsc_pkg::rsc_radio_state_type next_state, // State to move to.
  output logic preamble_restart, // With a transmit decision after a sent packet, resend preamble.
  output logic loops_frozen, // Hold offset and clock recovery loops.
  output logic [3:0] offset_gain, // Offset loop gain in units of K/2.
  output logic limit_enable, // Offset compensation saturation in use.
  output logic [1:0] limit_shift // Limit is channel bandwidth shifted right by this.
);

  // Refuse an address bus too narrow to reach the three register words.
  if (ADDR_WIDTH < rsc_pkg::MIN_ADDR_WIDTH) begin : g_addr_width_check
    $error("ADDR_WIDTH too narrow for the register addresses.");
  end

  localparam rsc_pkg::rsc_state_type RESET_STATE = '{
    next_state_reg: rsc_pkg::NEXT_STATE_RESET,
    calibration_reg: rsc_pkg::CALIBRATION_RESET,
    offset_comp_reg: rsc_pkg::OFFSET_COMP_RESET,
    next_state: rsc_pkg::RADIO_IDLE,
    default: '0
  };

  rsc_pkg::rsc_state_type state;
  rsc_pkg::rsc_state_type next_state_all;

  function automatic rsc_pkg::rsc_reg_sel_type decode_reg(input logic [ADDR_WIDTH-1:0] addr);
    if (addr == ADDR_WIDTH'(rsc_pkg::NEXT_STATE_ADDR)) begin
      return rsc_pkg::SEL_NEXT_STATE;
    end else if (addr == ADDR_WIDTH'(rsc_pkg::CALIBRATION_ADDR)) begin
      return rsc_pkg::SEL_CALIBRATION;
    end else if (addr == ADDR_WIDTH'(rsc_pkg::OFFSET_COMP_ADDR)) begin
      return rsc_pkg::SEL_OFFSET_COMP;
    end
    return rsc_pkg::SEL_NONE;
  endfunction

  always_comb begin
    rsc_pkg::rsc_reg_sel_type sel;
    logic [7:0] rd;
    logic write_now;
    logic [1:0] pre_k;
    sel = decode_reg(paddr);
    rd = 8'h00;
    write_now = 1'b0;
    pre_k = 2'h0;
    next_state_all = state;

    // The slave answers on the second access cycle so that every bus output is a flop.
    next_state_all.pready = psel & penable & ~state.pready;
    write_now = psel & penable & state.pready & pwrite;
    unique case (sel)
      rsc_pkg::SEL_NEXT_STATE: begin
        rd = state.next_state_reg;
      end
      rsc_pkg::SEL_CALIBRATION: begin
        rd = state.calibration_reg;
      end
      rsc_pkg::SEL_OFFSET_COMP: begin
        rd = state.offset_comp_reg;
      end
      rsc_pkg::SEL_NONE: begin
        rd = 8'h00;
      end
    endcase
    if (next_state_all.pready) begin
      next_state_all.prdata = pwrite ? 32'h0 : {24'h0, rd};
      next_state_all.pslverr = (sel == rsc_pkg::SEL_NONE);
    end
    if (write_now) begin
      // Reserved bits are stored as written; only unused bits are masked.
      unique case (sel)
        rsc_pkg::SEL_NEXT_STATE: begin
          next_state_all.next_state_reg = pwdata[7:0] & rsc_pkg::NEXT_STATE_MASK;
        end
        rsc_pkg::SEL_CALIBRATION: begin
          next_state_all.calibration_reg = pwdata[7:0] & rsc_pkg::CALIBRATION_MASK;
        end
        rsc_pkg::SEL_OFFSET_COMP: begin
          next_state_all.offset_comp_reg = pwdata[7:0] & rsc_pkg::OFFSET_COMP_MASK;
        end
        rsc_pkg::SEL_NONE: begin
        end
      endcase
    end

    unique case (rsc_pkg::rsc_clear_channel_select_type'(state.next_state_reg.clear_channel_select))
      rsc_pkg::CCA_ALWAYS: begin
        next_state_all.clear_channel = 1'b1;
      end
      rsc_pkg::CCA_RSSI_LOW: begin
        next_state_all.clear_channel = rssi_below_threshold;
      end
      rsc_pkg::CCA_NOT_RECEIVING: begin
        next_state_all.clear_channel = ~packet_receiving;
      end
      rsc_pkg::CCA_RSSI_LOW_NOT_RECEIVING: begin
        next_state_all.clear_channel = rssi_below_threshold & ~packet_receiving;
      end
    endcase

    // A received packet takes priority if both events coincide.
    // Clear channel combined with a transmit-side post-receive state is not checked here.
    next_state_all.next_state_valid = packet_received | packet_sent;
    next_state_all.preamble_restart = 1'b0;
    if (packet_received) begin
      next_state_all.next_state =
        rsc_pkg::rsc_radio_state_type'(state.next_state_reg.after_receive_state);
    end else if (packet_sent) begin
      next_state_all.next_state =
        rsc_pkg::rsc_radio_state_type'(state.next_state_reg.after_transmit_state);
      next_state_all.preamble_restart =
        (next_state_all.next_state == rsc_pkg::RADIO_TRANSMIT);
    end

    next_state_all.calibrate_request = calibrate_strobe;
    unique case (rsc_pkg::rsc_cal_mode_type'(state.calibration_reg.synth_auto_calibrate))
      rsc_pkg::CAL_NEVER: begin
      end
      rsc_pkg::CAL_ON_START: begin
        if (idle_exit) begin
          next_state_all.calibrate_request = 1'b1;
        end
      end
      rsc_pkg::CAL_ON_RETURN: begin
        if (auto_idle_return) begin
          next_state_all.calibrate_request = 1'b1;
        end
      end
      rsc_pkg::CAL_EVERY_FOURTH: begin
        if (auto_idle_return) begin
          next_state_all.cal_count = state.cal_count + 2'h1;
          if (state.cal_count == rsc_pkg::CAL_COUNT_LAST) begin
            next_state_all.calibrate_request = 1'b1;
          end
        end
      end
    endcase

    // A detection in the same cycle as a reception start wins, so it is never lost.
    next_state_all.carrier_seen = (state.carrier_seen & ~reception_start) | carrier_sense;
    next_state_all.sync_seen = (state.sync_seen & ~reception_start) | sync_detected;
    next_state_all.loops_frozen =
      state.offset_comp_reg.loops_carrier_gate & ~next_state_all.carrier_seen;

    pre_k = state.offset_comp_reg.offset_gain_presync;
    if (next_state_all.sync_seen & state.offset_comp_reg.offset_gain_postsync) begin
      next_state_all.offset_gain = rsc_pkg::GAIN_HALF_K;
    end else begin
      // Widen before adding, since 4K would otherwise wrap to zero.
      next_state_all.offset_gain = {({1'b0, pre_k} + 3'h1), 1'b0};
    end

    next_state_all.limit_enable =
      (state.offset_comp_reg.offset_saturation_limit != rsc_pkg::LIMIT_NONE);
    unique case (state.offset_comp_reg.offset_saturation_limit)
      rsc_pkg::LIMIT_NONE: begin
        next_state_all.limit_shift = 2'h0;
      end
      rsc_pkg::LIMIT_EIGHTH: begin
        next_state_all.limit_shift = rsc_pkg::SHIFT_EIGHTH;
      end
      rsc_pkg::LIMIT_QUARTER: begin
        next_state_all.limit_shift = rsc_pkg::SHIFT_QUARTER;
      end
      default: begin
        next_state_all.limit_shift = rsc_pkg::SHIFT_HALF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state_all;
    end
  end

  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign prdata = state.prdata;
  assign clear_channel = state.clear_channel;
  assign calibrate_request = state.calibrate_request;
  assign next_state_valid = state.next_state_valid;
  assign next_state = state.next_state;
  assign preamble_restart = state.preamble_restart;
  assign loops_frozen = state.loops_frozen;
  assign offset_gain = state.offset_gain;
  assign limit_enable = state.limit_enable;
  assign limit_shift = state.limit_shift;

endmodule // rsc_radio_config

`default_nettype wire

//--- verif/rsc_radio_config_chk.sv
// Port-level assertions for the radio state and offset register bank.
`timescale 1ns/10ps
`default_nettype none
module rsc_radio_config_chk (
  input wire logic pclk, presetn, psel, penable, pwrite, // APB clock, reset, control.
  input wire logic pready, pslverr, // APB answer.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic rssi_below_threshold, packet_receiving, // Channel levels.
  input wire logic packet_received, packet_sent, calibrate_strobe, carrier_sense, // Events.
  input wire logic clear_channel, calibrate_request, next_state_valid, // Indications.
  input wire rsc_pkg::rsc_radio_state_type next_state, // Decision.
  input wire logic preamble_restart, loops_frozen, limit_enable, // Loop controls.
  input wire logic [3:0] offset_gain, // Loop gain.
  input wire logic [1:0] limit_shift // Limit shift.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not after one wait state");
  a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_cca_open: assert property (rssi_below_threshold && !packet_receiving |=> clear_channel)
    else $error("clear channel low on a quiet channel");
  a_decision_pulse: assert property (packet_received || packet_sent |=> next_state_valid)
    else $error("no decision after packet event");
  a_no_decision: assert property (!(packet_received || packet_sent) |=> !next_state_valid)
    else $error("decision without packet event");
  a_preamble_tx: assert property (preamble_restart |->
    next_state_valid && next_state == rsc_pkg::RADIO_TRANSMIT)
    else $error("preamble restart without transmit decision");
  a_strobe_cal: assert property (calibrate_strobe |=> calibrate_request)
    else $error("strobe did not calibrate");
  a_carrier_thaw: assert property (carrier_sense |=> ##1 !loops_frozen)
    else $error("loops still frozen after carrier");
  a_limit_shift: assert property (limit_enable |-> limit_shift != 2'h0)
    else $error("limit enabled with zero shift");
  a_gain_legal: assert property ($past(presetn) |->
    offset_gain inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8})
    else $error("offset gain outside legal set");
  c_preamble: cover property (next_state_valid && preamble_restart);
  c_cal: cover property (calibrate_request);
  c_err: cover property (pready && pslverr);
endmodule // rsc_radio_config_chk
`default_nettype wire

//--- verif/rsc_radio_config_tb.sv
// Self-checking bench for the radio state and offset register bank.
`timescale 1ns/10ps
`default_nettype none
module rsc_radio_config_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata;
  logic rssi_below_threshold, packet_receiving, packet_received, packet_sent, idle_exit;
  logic auto_idle_return, calibrate_strobe, reception_start, sync_detected, carrier_sense;
  logic clear_channel, calibrate_request, next_state_valid, preamble_restart, loops_frozen;
  logic limit_enable;
  logic [1:0] limit_shift;
  logic [3:0] offset_gain;
  rsc_pkg::rsc_radio_state_type next_state;
  logic [7:0] ev;
  logic [32:0] rd_q[$];
  logic [2:0] ns_q[$];
  logic [19:0] ad[3] = '{rsc_pkg::NEXT_STATE_ADDR, rsc_pkg::CALIBRATION_ADDR,
    rsc_pkg::OFFSET_COMP_ADDR};
  logic [7:0] wm[3] = '{8'hff, 8'hf0, 8'hbf};
  logic [7:0] wo[3] = '{8'h00, 8'h04, 8'h00};
  logic [7:0] rm[3] = '{8'h3f, 8'h3f, 8'h7f};
  int miscompares, n_checks, seed;
  assign {carrier_sense, sync_detected, reception_start, calibrate_strobe} = ev[7:4];
  assign {auto_idle_return, idle_exit, packet_sent, packet_received} = ev[3:0];
  rsc_radio_config DUT (.*);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // The request is held until the edge that samples pready high.
  task automatic apb(input logic w, input logic [19:0] a, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] d, input logic err);
    rd_q.push_back({err, 24'h0, d});
    apb(1'b0, a, 8'h0);
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 8'h0;
    #1;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rd_q.size() > 0) chk("read", rd_q.pop_front(), {pslverr, prdata});
      else begin
        miscompares++;
        $display("MISMATCH read expected none seen %h", prdata);
      end
    end
    if (next_state_valid === 1'b1) begin
      if (ns_q.size() > 0) chk("decision", ns_q.pop_front(), {preamble_restart, next_state});
      else begin
        miscompares++;
        $display("MISMATCH decision expected none seen %h", next_state);
      end
    end
  end
  initial begin
    int m, k, e, j;
    logic [7:0] d;
    seed = 32'h65be;
    {psel, penable, pwrite, paddr, pwdata, ev} = '0;
    {rssi_below_threshold, packet_receiving} = 2'b00;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ad[0], 8'h30, 1'b0);
    rd(ad[1], 8'h04, 1'b0);
    rd(ad[2], 8'h76, 1'b0);
    apb(1'b1, 20'h00100, 8'hff);
    rd(20'h00100, 8'h00, 1'b1);
    for (k = 0; k < 6; k++) begin
      d = ($random(seed) & wm[k%3]) | wo[k%3];
      apb(1'b1, ad[k%3], d);
      rd(ad[k%3], d & rm[k%3], 1'b0);
    end
    for (m = 0; m < 4; m++) begin
      apb(1'b1, ad[0], {2'b00, m[1:0], 4'h0});
      for (k = 0; k < 4; k++) begin
        @(posedge pclk);
        rssi_below_threshold <= k[0];
        packet_receiving <= k[1];
        repeat (2) @(posedge pclk);
        #1;
        chk("clear_channel", m == 0 || (k[0] || m == 2) && (!k[1] || m == 1), clear_channel);
      end
    end
    // The clear channel mode stays 00 so every post-receive state is legal to select.
    for (k = 0; k < 16; k++) begin
      apb(1'b1, ad[0], {4'h0, k[3:0]});
      ns_q.push_back({1'b0, k[3:2]});
      pulse(8'h01);
      ns_q.push_back({k[1:0] == 2'h2, k[1:0]});
      pulse(8'h02);
    end
    ns_q.push_back({1'b0, 2'h3});
    pulse(8'h03);
    for (m = 0; m < 4; m++) begin
      apb(1'b1, ad[1], {2'b00, m[1:0], 4'h4});
      for (e = 0; e < 3; e++)
        for (j = 0; j < ((m == 3 && e == 1) ? 4 : 1); j++) begin
          pulse(8'h04 << e);
          chk("cal", e == 2 || (e == 0 && m == 1) || (e == 1 && (m == 2 || j == 3)),
            calibrate_request);
        end
    end
    for (m = 0; m < 4; m++) begin
      apb(1'b1, ad[2], {3'b001, m[1:0], m[0], m[1:0]});
      pulse(8'h20);
      @(posedge pclk);
      #1;
      chk("presync", {1'b1, 4'(2*m+2), m != 0, 2'(4-m)},
        {loops_frozen, offset_gain, limit_enable, limit_shift});
      pulse(8'h40);
      @(posedge pclk);
      #1;
      chk("postsync", m[0] ? 4'h1 : 4'(2*m+2), offset_gain);
      pulse(8'h80);
      @(posedge pclk);
      #1;
      chk("thaw", 1'b0, loops_frozen);
    end
    repeat (3) @(posedge pclk);
    chk("left", 0, rd_q.size() + ns_q.size());
    complete_run();
  end
endmodule // rsc_radio_config_tb
bind rsc_radio_config rsc_radio_config_chk CHK (.*);
`default_nettype wire
